// ==== core/sync_line_core.sv ====
// One synchronous line: shared and per-channel line registers, clocking, requests.
// Assumes channel-program strobes are one clock wide and on clk_i; pins are asynchronous.
`timescale 1ns/100ps
module sync_line_core #(
  parameter int FIX_DIV = sync_line_pkg::FIXED_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cp_tx_sel_i,
  input  wire logic [2:0] cp_addr_i,
  input  wire logic       cp_wr_i,
  input  wire logic       cp_rd_i,
  input  wire logic [7:0] cp_wdata_i,
  output logic      [7:0] cp_rdata_o,
  input  wire logic       tx_parity_en_i,
  input  wire logic       tx_parity_odd_i,
  output logic            rx_req_o,
  output logic            tx_req_o,
  output logic      [7:0] dss_data_o,
  input  wire logic       copy_en_i,
  input  wire logic [7:0] copy_mask_i,
  output logic            status_copy_o,
  output logic      [7:0] status_copy_data_o,
  input  wire logic       rxd_i,
  input  wire logic       rxc_i,
  input  wire logic       txc_i,
  input  wire logic       cts_i,
  input  wire logic       dsr_i,
  input  wire logic       dcd_i,
  input  wire logic       ri_i,
  output logic            txd_o,
  output logic            dtr_o,
  output logic            rts_o,
  output logic            speed_sel_o
);
  localparam int DIV_W = $clog2(FIX_DIV + 1);
  localparam int P_RXD = 0;
  localparam int P_RXC = 1;
  localparam int P_TXC = 2;
  localparam int P_CTS = 3;
  localparam int P_DSR = 4;
  localparam int P_DCD = 5;
  localparam int P_RI  = 6;

  typedef struct packed {
    logic [6:0]       pin_s1;
    logic [6:0]       pin_s2;
    logic             rxc_old;
    logic             txc_old;
    logic [DIV_W-1:0] div_cnt;
    logic             fix_tick;
    logic [7:0]       ctrl;
    logic [7:0]       sync_pat;
    logic [7:0]       fill_pat;
    logic [7:0]       cfg;
    logic [7:0]       status;
    logic [7:0]       rx_data;
    logic [7:0]       tx_data;
    logic             rx_full;
    logic             tx_empty;
    logic             hunt;
    logic [7:0]       rdata;
    logic             copy_pulse;
    logic [7:0]       copy_data;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;

  char_lane_if rx_lane ();
  char_lane_if tx_lane ();

  logic internal_clk;
  logic rx_tick;
  logic tx_tick;
  logic loop_on;

  // ****************************************
  // Bit clock selection
  // ****************************************
  // Direct connect and loop-back both run from the fixed-rate divider
  assign loop_on      = st_reg.ctrl[sync_line_pkg::CTL_LOOP];
  assign internal_clk = st_reg.ctrl[sync_line_pkg::CTL_DIRECT] | loop_on;
  assign rx_tick = st_reg.ctrl[sync_line_pkg::CTL_RX_ON] &
                   (internal_clk ? st_reg.fix_tick
                                 : (st_reg.pin_s2[P_RXC] & ~st_reg.rxc_old));
  assign tx_tick = st_reg.ctrl[sync_line_pkg::CTL_TX_ON] &
                   (internal_clk ? st_reg.fix_tick
                                 : (~st_reg.pin_s2[P_TXC] & st_reg.txc_old));

  // ****************************************
  // Lanes to the shifters
  // ****************************************
  assign rx_lane.tick     = rx_tick;
  assign rx_lane.len_code = st_reg.cfg[sync_line_pkg::CFG_LEN_HI:sync_line_pkg::CFG_LEN_LO];
  assign rx_lane.pattern  = st_reg.sync_pat;
  assign rx_lane.hunt     = st_reg.hunt;
  // Loop-back feeds the transmitter's bit straight into the receiver
  assign rx_lane.bit_val  = loop_on ? tx_lane.bit_val : st_reg.pin_s2[P_RXD];
  assign tx_lane.tick     = tx_tick;
  assign tx_lane.len_code = rx_lane.len_code;  // [RQ13] [RQ14]
  assign tx_lane.pattern  = st_reg.fill_pat;
  assign tx_lane.hunt     = ~st_reg.tx_empty;
  assign tx_lane.word     = st_reg.tx_data;

  rx_char_shifter u_rx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lane  (rx_lane.rx_shift)
  );

  tx_char_shifter u_tx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lane  (tx_lane.tx_shift)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic       wr_ctrl;
    logic       recv;
    logic       send;
    logic [7:0] mask;
    logic [7:0] low_mask;
    logic [7:0] tx_word;
    logic [7:0] status_now;
    logic [1:0] len_code;
    logic       parity;
    st_next    = st_reg;
    len_code   = rx_lane.len_code;
    mask       = sync_line_pkg::len_mask(len_code);
    low_mask   = mask >> 1;
    wr_ctrl    = cp_wr_i & (cp_addr_i == sync_line_pkg::LR_CTRL);
    recv       = cp_rd_i & ~cp_tx_sel_i & (cp_addr_i == sync_line_pkg::LR_DATA);
    send       = cp_wr_i & cp_tx_sel_i & (cp_addr_i == sync_line_pkg::LR_DATA);
    tx_word    = cp_wdata_i & mask;  // [RQ15]
    parity     = ^(tx_word & low_mask) ^ tx_parity_odd_i;
    status_now = 8'h00;

    // Pin synchronisers and edge history
    st_next.pin_s1  = {ri_i, dcd_i, dsr_i, cts_i, txc_i, rxc_i, rxd_i};
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.rxc_old = st_reg.pin_s2[P_RXC];
    st_next.txc_old = st_reg.pin_s2[P_TXC];

    // Fixed-rate bit enable
    st_next.fix_tick = 1'b0;
    if (st_reg.div_cnt == DIV_W'(FIX_DIV - 1)) begin
      st_next.div_cnt  = '0;
      st_next.fix_tick = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + DIV_W'(1);
    end

    // Register writes; one copy of control and configuration for both channels
    if (wr_ctrl) begin
      st_next.ctrl = cp_wdata_i;  // [RQ4]
    end
    if (cp_wr_i && cp_addr_i == sync_line_pkg::LR_CONFIG) begin
      st_next.cfg = cp_wdata_i;  // [RQ1] [RQ13]
    end
    if (cp_wr_i && cp_addr_i == sync_line_pkg::LR_PATTERN) begin
      if (cp_tx_sel_i) begin
        st_next.fill_pat = cp_wdata_i;  // [RQ24]
      end else begin
        st_next.sync_pat = cp_wdata_i;  // [RQ24]
      end
    end
    if (send) begin
      st_next.tx_data = tx_word;
      // No parity slot exists in five-bit mode
      if (tx_parity_en_i && len_code != sync_line_pkg::LEN_FIVE) begin  // [RQ10] [RQ16]
        st_next.tx_data = tx_word | (mask & ~low_mask & {8{parity}});  // [RQ17]
      end
    end

    // Receive-on rising edge restarts the search
    if (wr_ctrl && cp_wdata_i[sync_line_pkg::CTL_RX_ON] &&
        !st_reg.ctrl[sync_line_pkg::CTL_RX_ON]) begin
      st_next.hunt = 1'b1;  // [RQ23]
    end else if (rx_lane.strobe) begin
      st_next.hunt = 1'b0;
    end

    // Set wins over clear on both request flags
    if (rx_lane.strobe) begin
      st_next.rx_data = rx_lane.word;  // [RQ2]
    end
    st_next.rx_full  = rx_lane.strobe | (st_reg.rx_full & ~recv);  // [RQ22]
    st_next.tx_empty = tx_lane.strobe | (st_reg.tx_empty & ~send);  // [RQ22]

    // Status and change copy
    status_now[sync_line_pkg::ST_DSR]  = st_reg.pin_s2[P_DSR];
    status_now[sync_line_pkg::ST_CTS]  = st_reg.pin_s2[P_CTS];
    status_now[sync_line_pkg::ST_DCD]  = st_reg.pin_s2[P_DCD];
    status_now[sync_line_pkg::ST_RING] = st_reg.pin_s2[P_RI];
    st_next.status     = status_now;  // [RQ11]
    st_next.copy_pulse = copy_en_i & |((status_now ^ st_reg.status) & copy_mask_i);  // [RQ12]
    if (st_next.copy_pulse) begin
      st_next.copy_data = status_now;  // [RQ12]
    end

    // Channel-program reads
    if (cp_rd_i) begin
      case (cp_addr_i)
        sync_line_pkg::LR_DATA:    st_next.rdata = cp_tx_sel_i ? 8'h00 : st_reg.rx_data;
        sync_line_pkg::LR_CTRL:    st_next.rdata = st_reg.ctrl;
        sync_line_pkg::LR_PATTERN: st_next.rdata = cp_tx_sel_i ? st_reg.fill_pat
                                                               : st_reg.sync_pat;
        sync_line_pkg::LR_STATUS:  st_next.rdata = st_reg.status;
        sync_line_pkg::LR_CONFIG:  st_next.rdata = st_reg.cfg;
        default:                   st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg          <= '0;
      st_reg.ctrl     <= sync_line_pkg::CTRL_RST;
      st_reg.sync_pat <= sync_line_pkg::PATTERN_RST;
      st_reg.fill_pat <= sync_line_pkg::PATTERN_RST;
      st_reg.cfg      <= sync_line_pkg::CONFIG_RST;
      st_reg.tx_empty <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cp_rdata_o         = st_reg.rdata;
  assign dss_data_o         = st_reg.status;  // [RQ11]
  assign status_copy_o      = st_reg.copy_pulse;
  assign status_copy_data_o = st_reg.copy_data;
  // Receive request stays off during the hunt; transmit request stays off without the transmit permissions
  assign rx_req_o = st_reg.rx_full & ~st_reg.hunt &
                    st_reg.ctrl[sync_line_pkg::CTL_RX_ON];  // [RQ22] [RQ23]
  assign tx_req_o = st_reg.tx_empty & st_reg.ctrl[sync_line_pkg::CTL_TX_ON] &
                    st_reg.ctrl[sync_line_pkg::CTL_RTS] &
                    st_reg.status[sync_line_pkg::ST_CTS];  // [RQ22]
  // Line held at mark while off or looped back
  assign txd_o = (loop_on | ~st_reg.ctrl[sync_line_pkg::CTL_TX_ON]) ? sync_line_pkg::MARK
                                                                    : tx_lane.bit_val;
  assign dtr_o       = st_reg.ctrl[sync_line_pkg::CTL_DTR];
  assign rts_o       = st_reg.ctrl[sync_line_pkg::CTL_RTS];
  assign speed_sel_o = st_reg.ctrl[sync_line_pkg::CTL_SPEED];
endmodule : sync_line_core

// ==== shared/sync_line_pkg.sv ====
// Constants, field positions and shared helpers for one synchronous line.
// Assumes a single 250 MHz clock and registers reached by channel-program strobes.
//
// Summary of operation
// RQ1: Each channel sees eight line registers; control, status, configuration exist once per line.
// RQ2: Configuration bits 0-1 size received characters; short characters right-justified, upper zero.
// RQ3: First received serial bit goes to the top bit of the character field.
// RQ4: Control register writes from either channel steer both receiver and transmitter at once.
// RQ5: Channel program loads control register from line control table byte 20.
// RQ6: Receiver hunts for alignment using its sync-pattern register, customarily 16 hex.
// RQ7: Software sets unused upper sync-pattern bits to one for short characters.
// RQ8: Software computes sync-pattern parity, placed at top of configured length.
// RQ9: For parity-checked reception the sync pattern already carries correct parity.
// RQ10: Five-bit characters never carry parity, receive or transmit.
// RQ11: Shared status register shows data set state, readable by main memory program.
// RQ12: Enabled, unmasked status change copies the whole status register to the table.
// RQ13: Configuration register writes from either channel affect both channels.
// RQ14: Parity and check-code fields of the configuration byte are ignored.
// RQ15: Transmit upper unused bits are zero; character right-justified, upper bits never sent.
// RQ16: Parity position arrives zero; correct parity is inserted on load into transmit data.
// RQ17: Generated parity sits at top of configured length and is transmitted.
// RQ18: Transmitter sends the top bit of the character first.
// RQ19: Fill pattern is sent when idle and on transmit underrun, customarily 16 hex.
// RQ20: Software sets unused upper fill-pattern bits to one for short characters.
// RQ21: Software preloads correct parity into the fill pattern when parity is generated.
// RQ22: Service request on new received character and on empty transmit data register.
// RQ23: On receive-on rising, compare after every bit; no request until sync match.
// RQ24: Fill, sync and configuration registers hold until rewritten and apply continuously.
package sync_line_pkg;

  localparam int CLK_HZ       = 250_000_000;
  localparam int FIXED_BIT_HZ = 19_200;
  localparam int FIXED_DIV    = CLK_HZ / FIXED_BIT_HZ;

  // ****************************************
  // Line register numbers
  // ****************************************
  localparam logic [2:0] LR_DATA    = 3'h1;
  localparam logic [2:0] LR_CTRL    = 3'h2;
  localparam logic [2:0] LR_PATTERN = 3'h4;
  localparam logic [2:0] LR_STATUS  = 3'h5;
  localparam logic [2:0] LR_CONFIG  = 3'h6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_DTR    = 0;
  localparam int CTL_RTS    = 1;
  localparam int CTL_SPEED  = 3;
  localparam int CTL_DIRECT = 4;
  localparam int CTL_LOOP   = 5;
  localparam int CTL_RX_ON  = 6;
  localparam int CTL_TX_ON  = 7;
  localparam int ST_DSR     = 0;
  localparam int ST_CTS     = 1;
  localparam int ST_DCD     = 2;
  localparam int ST_RING    = 3;
  localparam int CFG_LEN_LO = 0;
  localparam int CFG_LEN_HI = 1;

  // ****************************************
  // Reset values and line constants
  // ****************************************
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] PATTERN_RST = 8'h16;
  localparam logic [7:0] CONFIG_RST  = 8'h03;
  localparam logic       MARK        = 1'b1;
  localparam logic [1:0] LEN_FIVE    = 2'h0;

  // Bits per character: code 0..3 gives 5..8
  function automatic logic [3:0] char_bits(input logic [1:0] code);
    char_bits = 4'h5 + {2'h0, code};
  endfunction : char_bits

  function automatic logic [7:0] len_mask(input logic [1:0] code);
    len_mask = 8'hFF >> (2'h3 - code);
  endfunction : len_mask

endpackage : sync_line_pkg

// ==== shared/char_lane_if.sv ====
// Carrier between the line core and one character shifter.
// Assumes the core drives bit ticks already qualified by the channel enable.
`timescale 1ns/100ps
interface char_lane_if;
  logic       tick;
  logic [1:0] len_code;
  logic [7:0] pattern;
  logic       hunt;
  logic       bit_val;
  logic [7:0] word;
  logic       strobe;

  modport rx_shift (input tick, len_code, pattern, hunt, bit_val, output word, strobe);
  modport tx_shift (input tick, len_code, pattern, hunt, word, output bit_val, strobe);
endinterface : char_lane_if

// ==== core/rx_char_shifter.sv ====
// Receive shift buffer: sync hunt and character assembly.
// Assumes one tick per received bit; hunt is held by the core until it sees strobe.
`timescale 1ns/100ps
module rx_char_shifter (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  char_lane_if.rx_shift lane
);
  typedef struct packed {
    logic [7:0] shift;
    logic [3:0] count;
    logic [7:0] word;
    logic       strobe;
  } rx_state_t;

  rx_state_t st_reg;
  rx_state_t st_next;

  always_comb begin
    logic [7:0] mask;
    logic [7:0] shifted;
    mask    = sync_line_pkg::len_mask(lane.len_code);
    shifted = {st_reg.shift[6:0], lane.bit_val};  // [RQ3]
    st_next = st_reg;
    st_next.strobe = 1'b0;
    if (lane.tick) begin
      st_next.shift = shifted;
      if (lane.hunt) begin
        st_next.count = 4'h0;
        // Upper pattern bits are masked, so loose fill bits cannot block a match
        if ((shifted & mask) == (lane.pattern & mask)) begin  // [RQ6] [RQ23]
          st_next.word   = shifted & mask;
          st_next.strobe = 1'b1;
        end
      end else if (st_reg.count + 4'h1 == sync_line_pkg::char_bits(lane.len_code)) begin
        st_next.count  = 4'h0;
        st_next.word   = shifted & mask;  // [RQ2]
        st_next.strobe = 1'b1;
      end else begin
        st_next.count = st_reg.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane.word   = st_reg.word;
  assign lane.strobe = st_reg.strobe;
endmodule : rx_char_shifter

// ==== core/tx_char_shifter.sv ====
// Transmit shift buffer: loads a character or the fill pattern per character slot.
// Assumes hunt means the transmit data register holds a character.
`timescale 1ns/100ps
module tx_char_shifter (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  char_lane_if.tx_shift lane
);
  typedef struct packed {
    logic [7:0] shift;
    logic [3:0] left;
    logic       bit_val;
    logic       strobe;
  } tx_state_t;

  tx_state_t st_reg;
  tx_state_t st_next;

  always_comb begin
    logic [7:0] src;
    logic [3:0] bits;
    logic [7:0] aligned;
    bits    = sync_line_pkg::char_bits(lane.len_code);
    // Underrun and idle both fall back to the fill pattern
    src     = lane.hunt ? lane.word : lane.pattern;  // [RQ19] [RQ24]
    aligned = (src & sync_line_pkg::len_mask(lane.len_code)) << (4'h8 - bits);  // [RQ15]
    st_next = st_reg;
    st_next.strobe = 1'b0;
    if (lane.tick) begin
      if (st_reg.left == 4'h0) begin
        st_next.bit_val = aligned[7];  // [RQ18] [RQ17]
        st_next.shift   = {aligned[6:0], 1'b0};
        st_next.left    = bits - 4'h1;
        st_next.strobe  = lane.hunt;
      end else begin
        st_next.bit_val = st_reg.shift[7];
        st_next.shift   = {st_reg.shift[6:0], 1'b0};
        st_next.left    = st_reg.left - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.bit_val <= sync_line_pkg::MARK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane.bit_val = st_reg.bit_val;
  assign lane.strobe  = st_reg.strobe;
endmodule : tx_char_shifter

// ==== tb/sync_line_checker.sv ====
// Port assertions for the synchronous line core.
// Assumes one clock domain and the register-port timing of the hand-over.
`timescale 1ns/100ps
module sync_line_checker #(
  parameter int FIX_DIV = sync_line_pkg::FIXED_DIV
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cp_tx_sel_i,
  input wire logic [2:0] cp_addr_i,
  input wire logic       cp_wr_i,
  input wire logic       cp_rd_i,
  input wire logic [7:0] cp_wdata_i,
  input wire logic [7:0] cp_rdata_o,
  input wire logic       rx_req_o,
  input wire logic       tx_req_o,
  input wire logic [7:0] dss_data_o,
  input wire logic       copy_en_i,
  input wire logic       status_copy_o,
  input wire logic       txd_o,
  input wire logic       dtr_o,
  input wire logic       rts_o,
  input wire logic       speed_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Properties
  // ****************************************
  property p_reset_out;
    disable iff (1'b0) rst_i |=> !rx_req_o && !tx_req_o && !status_copy_o && txd_o
      && cp_rdata_o == 8'h00 && dss_data_o == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");
  property p_unmapped_rd;
    cp_rd_i && cp_addr_i == 3'h3 |=> cp_rdata_o == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_txdata_rd;
    cp_rd_i && cp_tx_sel_i && cp_addr_i == sync_line_pkg::LR_DATA |=> cp_rdata_o == 8'h00;
  endproperty
  a_txdata_rd: assert property (p_txdata_rd) else $error("tx data readable");
  property p_rdata_hold;
    !$past(cp_rd_i) |-> $stable(cp_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_send_clears;
    cp_wr_i && cp_tx_sel_i && cp_addr_i == sync_line_pkg::LR_DATA |=> !tx_req_o;
  endproperty
  a_send_clears: assert property (p_send_clears) else $error("tx request after send");
  property p_recv_clears;
    cp_rd_i && !cp_tx_sel_i && cp_addr_i == sync_line_pkg::LR_DATA && rx_req_o |=> !rx_req_o;
  endproperty
  a_recv_clears: assert property (p_recv_clears) else $error("rx request after recv");
  property p_ctrl_pins;
    cp_wr_i && cp_addr_i == sync_line_pkg::LR_CTRL |=> dtr_o == $past(cp_wdata_i[0])
      && rts_o == $past(cp_wdata_i[1]) && speed_sel_o == $past(cp_wdata_i[3]);
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins) else $error("control pins wrong");
  property p_tx_req_cts;
    tx_req_o |-> dss_data_o[sync_line_pkg::ST_CTS];
  endproperty
  a_tx_req_cts: assert property (p_tx_req_cts) else $error("tx request without cts");
  property p_copy_pulse;
    status_copy_o |-> $past(copy_en_i) ##1 !status_copy_o;
  endproperty
  a_copy_pulse: assert property (p_copy_pulse) else $error("bad status copy pulse");
  property p_mark_off;
    cp_wr_i && cp_addr_i == sync_line_pkg::LR_CTRL && !cp_wdata_i[7] |-> ##2 txd_o;
  endproperty
  a_mark_off: assert property (p_mark_off) else $error("txd not mark when off");

  c_rx_req: cover property ($rose(rx_req_o));
  c_tx_req: cover property ($rose(tx_req_o));
  c_copy:   cover property (status_copy_o);
endmodule : sync_line_checker

bind sync_line_core sync_line_checker #(.FIX_DIV(FIX_DIV)) u_sync_line_checker (
  .clk_i, .rst_i, .cp_tx_sel_i, .cp_addr_i, .cp_wr_i, .cp_rd_i, .cp_wdata_i, .cp_rdata_o,
  .rx_req_o, .tx_req_o, .dss_data_o, .copy_en_i, .status_copy_o, .txd_o, .dtr_o, .rts_o,
  .speed_sel_o
);

// ==== tb/modem_model.sv ====
// Behavioural synchronous data set with 160 ns bit clocks.
// Assumes the core samples rxd on rising rxc and shifts txd on falling txc.
`timescale 1ns/100ps
module modem_model (
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      rxc_o,
  output logic      txc_o,
  output logic      cts_o,
  output logic      dsr_o,
  output logic      dcd_o,
  output logic      ri_o
);
  logic [63:0] cap;

  initial begin
    rxd_o = 1'b1;
    rxc_o = 1'b0;
    txc_o = 1'b1;
    {ri_o, dcd_o, cts_o, dsr_o} = 4'h3;
    cap = 64'h0;
  end

  // ****************************************
  // Frames: clocks stand still outside them
  // ****************************************
  task automatic send_bits(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rxd_o = bits[i];
      #80 rxc_o = 1'b1;
      #80 rxc_o = 1'b0;
    end
    // Idle: inverse
    rxd_o = ~rxd_o;
  endtask : send_bits

  task automatic capture(input int n);
    for (int i = 0; i < n; i++) begin
      txc_o = 1'b0;
      #80 txc_o = 1'b1;
      cap = {cap[62:0], txd_i};
      #80;
    end
  endtask : capture

  task automatic set_status(input logic [3:0] s);
    {ri_o, dcd_o, cts_o, dsr_o} = s;
  endtask : set_status
endmodule : modem_model

// ==== tb/tb_top.sv ====
// Self-checking bench for one synchronous line core.
// Assumes the modem model on the line side and no random stimulus.
`timescale 1ns/100ps
module tb_top;
  logic       clk_i          = 1'b0;
  logic       rst_i          = 1'b1;
  logic       cp_tx_sel_i    = 1'b0;
  logic [2:0] cp_addr_i      = 3'h0;
  logic       cp_wr_i        = 1'b0;
  logic       cp_rd_i        = 1'b0;
  logic [7:0] cp_wdata_i     = 8'h00;
  logic       tx_parity_en_i = 1'b0;
  logic       copy_en_i      = 1'b0;
  logic [7:0] copy_mask_i    = 8'h00;
  logic [7:0] cp_rdata_o, dss_data_o, status_copy_data_o;
  logic       rx_req_o, tx_req_o, status_copy_o, txd_o, dtr_o, rts_o, speed_sel_o;
  logic       rxd, rxc, txc, cts, dsr, dcd, ri;
  int         failures  = 0;
  int         num_checks = 0;

  always #2 clk_i = ~clk_i;

  sync_line_core #(.FIX_DIV(8)) u_sync_line_core (
    .clk_i, .rst_i, .cp_tx_sel_i, .cp_addr_i, .cp_wr_i, .cp_rd_i, .cp_wdata_i, .cp_rdata_o,
    .tx_parity_en_i, .tx_parity_odd_i(1'b0), .rx_req_o, .tx_req_o, .dss_data_o, .copy_en_i,
    .copy_mask_i, .status_copy_o, .status_copy_data_o, .rxd_i(rxd), .rxc_i(rxc),
    .txc_i(txc), .cts_i(cts), .dsr_i(dsr), .dcd_i(dcd), .ri_i(ri), .txd_o, .dtr_o, .rts_o,
    .speed_sel_o
  );
  modem_model u_modem_model (
    .txd_i(txd_o), .rxd_o(rxd), .rxc_o(rxc), .txc_o(txc), .cts_o(cts), .dsr_o(dsr),
    .dcd_o(dcd), .ri_o(ri)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic wr(input logic sel, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    {cp_tx_sel_i, cp_addr_i, cp_wdata_i, cp_wr_i} = {sel, a, d, 1'b1};
    @(posedge clk_i);
    #1 cp_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic sel, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    {cp_tx_sel_i, cp_addr_i, cp_rd_i} = {sel, a, 1'b1};
    @(posedge clk_i);
    #1 cp_rd_i = 1'b0;
    d = cp_rdata_o;
  endtask : rd

  // Signal 0 rx request, 1 tx request, 2 status copy
  task automatic wait_sig(input int s, input int n);
    int k;
    k = 0;
    while (((s == 0) ? rx_req_o : (s == 1) ? tx_req_o : status_copy_o) !== 1'b1 && k < n) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k == n) begin
      failures++;
      $display("Error wait %0d expected 1 seen 0", s);
      report_and_stop();
    end
  endtask : wait_sig

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] d;
    rd(0, sync_line_pkg::LR_CTRL, d);
    check8("ctrl", 8'h00, d);
    rd(0, sync_line_pkg::LR_PATTERN, d);
    check8("sync", 8'h16, d);
    rd(1, sync_line_pkg::LR_PATTERN, d);
    check8("fill", 8'h16, d);
    rd(1, sync_line_pkg::LR_CONFIG, d);
    check8("config", 8'h03, d);
    rd(0, 3'h3, d);
    check8("unmapped", 8'h00, d);
    rd(1, sync_line_pkg::LR_DATA, d);
    check8("tx data", 8'h00, d);
    wr(1, sync_line_pkg::LR_STATUS, 8'hF0);
    rd(1, sync_line_pkg::LR_STATUS, d);
    check8("status", 8'h03, d);
    $display("Test reset done");
  endtask : t_reset

  task automatic t_shared;
    logic [7:0] d;
    wr(1, sync_line_pkg::LR_CTRL, 8'h0B);
    rd(0, sync_line_pkg::LR_CTRL, d);
    check8("ctrl shared", 8'h0B, d);
    check8("pins", 8'h0B, {4'h0, speed_sel_o, 1'b0, rts_o, dtr_o});
    wr(0, sync_line_pkg::LR_CONFIG, 8'h02);
    rd(1, sync_line_pkg::LR_CONFIG, d);
    check8("config shared", 8'h02, d);
    wr(0, sync_line_pkg::LR_PATTERN, 8'h5A);
    rd(1, sync_line_pkg::LR_PATTERN, d);
    check8("fill own", 8'h16, d);
    wr(1, sync_line_pkg::LR_CTRL, 8'h00);
    $display("Test shared done");
  endtask : t_shared

  task automatic t_rx(input logic [7:0] cfg, pat, input logic [31:0] bits, input int n,
                      input logic [7:0] exp);
    logic [7:0] d;
    wr(0, sync_line_pkg::LR_CONFIG, cfg);
    wr(0, sync_line_pkg::LR_PATTERN, pat);
    wr(1, sync_line_pkg::LR_CTRL, 8'h00);
    wr(1, sync_line_pkg::LR_CTRL, 8'h40);
    fork
      u_modem_model.send_bits(bits, n);
      begin
        wait_sig(0, 2000);
        rd(0, sync_line_pkg::LR_DATA, d);
        check8("rx sync", 8'h16, d);
        wait_sig(0, 2000);
        rd(0, sync_line_pkg::LR_DATA, d);
        check8("rx data", exp, d);
      end
    join
    $display("Test rx done");
  endtask : t_rx

  task automatic t_tx(input logic [7:0] cfg, fill, input logic par, input logic [7:0] data,
                      input logic [63:0] exp, input int n);
    logic found;
    logic [63:0] mask;
    found = 1'b0;
    mask = (64'h1 << (2 * n)) - 64'h1;
    tx_parity_en_i = par;
    wr(1, sync_line_pkg::LR_CONFIG, cfg);
    wr(1, sync_line_pkg::LR_PATTERN, fill);
    wr(0, sync_line_pkg::LR_CTRL, 8'h82);
    wait_sig(1, 50);
    wr(1, sync_line_pkg::LR_DATA, data);
    check8("tx req sent", 8'h00, {7'h0, tx_req_o});
    u_modem_model.capture(40);
    wait_sig(1, 50);
    for (int i = 0; i <= 40 - 2 * n; i++)
      if (((u_modem_model.cap >> i) & mask) === exp) found = 1'b1;
    check8("tx stream", 8'h01, {7'h0, found});
    $display("Test tx done");
  endtask : t_tx

  task automatic t_status;
    logic [7:0] d;
    int         cnt;
    cnt = 0;
    copy_en_i = 1'b1;
    copy_mask_i = 8'h04;
    u_modem_model.set_status(4'hB);
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (status_copy_o === 1'b1) cnt++;
    end
    check8("copy masked", 8'h00, cnt[7:0]);
    u_modem_model.set_status(4'hF);
    wait_sig(2, 20);
    check8("copy data", 8'h0F, status_copy_data_o);
    check8("dss", 8'h0F, dss_data_o);
    rd(0, sync_line_pkg::LR_STATUS, d);
    check8("status", 8'h0F, d);
    $display("Test status done");
  endtask : t_status

  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_shared();
    t_rx(8'hF3, 8'h16, 32'h16A5, 19, 8'hA5);
    t_rx(8'h01, 8'hD6, 32'h5AD, 15, 8'h2D);
    t_tx(8'h03, 8'h16, 1'b0, 8'hA5, 64'hA516, 8);
    t_tx(8'h02, 8'hD6, 1'b1, 8'h01, 64'h20D6, 7);
    t_status();
    report_and_stop();
  end
endmodule : tb_top
